// ---- rtl/actc_core.sv ----
`timescale 1ns/100ps
`default_nettype none
module actc_core #(
    parameter int unsigned PWRUP_CYCLES = actc_pkg::PWRUP_CYC
) (
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          start_i,
    input  wire logic [actc_pkg::PRESC_W-1:0]  acquisition_window_prescaler_i,
    input  wire logic [actc_pkg::CODE_W-1:0]   analog_code_i,
    input  wire logic                          analog_over_i,
    input  wire logic                          analog_under_i,
    input  wire logic                          flag_clear_i,
    output logic                               sample_o,
    output logic                               convert_o,
    output logic                               busy_o,
    output logic [actc_pkg::CODE_W-1:0]        result_o,
    output logic                               done_flag_o,
    output logic                               conversion_done_irq_o
);
    actc_pkg::actc_state_type state;
    logic [actc_pkg::CNT_W-1:0]  cyc;
    logic [actc_pkg::CNT_W-1:0]  total;
    logic [actc_pkg::TICK_W-1:0] ticks;
    logic [actc_pkg::TICK_W-1:0] sh_len;
    logic [actc_pkg::TICK_W-1:0] sh_len_reg;
    logic [15:0]                 pwr_cnt;
    logic                        pwr_ok;
    logic                        tick;
    logic                        run_div;
    logic                        irq_pipe;
    logic                        load_go;

    localparam logic [actc_pkg::TICK_W-1:0] SH_MIN = actc_pkg::TICK_W'(actc_pkg::SH_MIN_TICKS);
    localparam logic [actc_pkg::TICK_W-1:0] CONV_T = actc_pkg::TICK_W'(actc_pkg::CONV_TICKS);
    localparam logic [actc_pkg::CNT_W-1:0]  SOC_C  = actc_pkg::CNT_W'(actc_pkg::SOC_DELAY_CYC);
    localparam logic [actc_pkg::CNT_W-1:0]  LOAD_C = actc_pkg::CNT_W'(actc_pkg::LOAD_DELAY_CYC);
    localparam logic [actc_pkg::CNT_W-1:0]  TOT_C  = actc_pkg::CNT_W'(actc_pkg::TOTAL_MIN_CYC);
    localparam logic [15:0]                 PWR_C  = 16'(PWRUP_CYCLES);
    localparam int                          SH_MAX_CYC = actc_pkg::SH_MAX_TICKS * actc_pkg::ADCLK_DIV;
    localparam int                          TOT_CYC    = actc_pkg::TOTAL_MIN_CYC;

    // field value n gives n+1 ticks, floor of two; 5 bits caps at 32
    always_comb begin
        sh_len = actc_pkg::TICK_W'(acquisition_window_prescaler_i) + 1'b1;
        if (sh_len < SH_MIN) begin
            sh_len = SH_MIN;
        end
    end

    assign run_div = (state == actc_pkg::ACTC_SAMPLE) || (state == actc_pkg::ACTC_CONVERT);

    actc_tick_div #(
        .DIV (actc_pkg::ADCLK_DIV)
    ) u_div (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (run_div),
        .tick_o    (tick)
    );

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_cnt <= 16'h0000;
            pwr_ok  <= 1'b0;
        end else if (!pwr_ok) begin
            pwr_cnt <= pwr_cnt + 16'h0001;
            pwr_ok  <= (pwr_cnt >= PWR_C - 16'h0001);
        end
    end

    // load also waits for the total floor, so short windows still take 500 ns
    assign load_go = (cyc >= LOAD_C - 1'b1) && (total >= TOT_C - LOAD_C);

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= actc_pkg::ACTC_IDLE;
            cyc        <= '0;
            ticks      <= '0;
            total      <= '0;
            sh_len_reg <= SH_MIN;
        end else begin
            if (state != actc_pkg::ACTC_IDLE && total != '1) begin
                total <= total + 1'b1;
            end
            case (state)
                actc_pkg::ACTC_IDLE: begin
                    cyc   <= '0;
                    total <= '0;
                    if (start_i) begin
                        sh_len_reg <= sh_len;
                        state      <= actc_pkg::ACTC_START;
                    end
                end
                actc_pkg::ACTC_START: begin
                    cyc <= cyc + 1'b1;
                    if (cyc == SOC_C - 1'b1) begin
                        cyc   <= '0;
                        ticks <= '0;
                        state <= actc_pkg::ACTC_SAMPLE;
                    end
                end
                actc_pkg::ACTC_SAMPLE: begin
                    if (tick) begin
                        ticks <= ticks + 1'b1;
                        if (ticks == sh_len_reg - 1'b1) begin
                            ticks <= '0;
                            state <= actc_pkg::ACTC_CONVERT;
                        end
                    end
                end
                actc_pkg::ACTC_CONVERT: begin
                    if (tick) begin
                        ticks <= ticks + 1'b1;
                        if (ticks == CONV_T - 1'b1) begin
                            cyc   <= '0;
                            state <= actc_pkg::ACTC_LOAD;
                        end
                    end
                end
                actc_pkg::ACTC_LOAD: begin
                    if (cyc != '1) begin
                        cyc <= cyc + 1'b1;
                    end
                    if (load_go) begin
                        state <= actc_pkg::ACTC_IDLE;
                    end
                end
                default: begin
                    state <= actc_pkg::ACTC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_o  <= 1'b0;
            convert_o <= 1'b0;
            busy_o    <= 1'b0;
        end else begin
            sample_o  <= (state == actc_pkg::ACTC_SAMPLE);
            convert_o <= (state == actc_pkg::ACTC_CONVERT);
            busy_o    <= (state != actc_pkg::ACTC_IDLE) || start_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            result_o <= actc_pkg::CODE_MIN;
        end else if (state == actc_pkg::ACTC_LOAD && load_go) begin
            if (analog_under_i) begin
                result_o <= actc_pkg::CODE_MIN;
            end else if (analog_over_i) begin
                result_o <= actc_pkg::CODE_MAX;
            end else begin
                result_o <= analog_code_i;
            end
        end
    end

    // set wins over clear; suppressed until analog stage settled
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_flag_o <= 1'b0;
        end else if (state == actc_pkg::ACTC_LOAD && load_go && pwr_ok) begin
            done_flag_o <= 1'b1;
        end else if (flag_clear_i) begin
            done_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_pipe              <= 1'b0;
            conversion_done_irq_o <= 1'b0;
        end else begin
            irq_pipe              <= done_flag_o;
            conversion_done_irq_o <= irq_pipe && done_flag_o;
        end
    end

    // busy has stood four samples when the window opens: three start cycles
    property p_soc_delay;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(sample_o) |-> $past(busy_o, 4);
    endproperty
    a_soc_delay: assert property (p_soc_delay)
        else $error("sample started without start delay");

    property p_sh_min;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(sample_o) |-> sample_o [*2];
    endproperty
    a_sh_min: assert property (p_sh_min)
        else $error("sample window too short");

    property p_sh_max;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(sample_o) |-> ##[1:SH_MAX_CYC] !sample_o;
    endproperty
    a_sh_max: assert property (p_sh_max)
        else $error("sample window too long");

    property p_conv_min;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(convert_o) |-> convert_o [*8] ##1 convert_o [*2];
    endproperty
    a_conv_min: assert property (p_conv_min)
        else $error("conversion phase too short");

    property p_total;
        @(posedge sys_clk_i) disable iff (rst_i)
        $fell(busy_o) |-> $past(busy_o, TOT_CYC);
    endproperty
    a_total: assert property (p_total)
        else $error("conversion shorter than floor");

    property p_irq;
        @(posedge sys_clk_i) disable iff (rst_i)
        $rose(done_flag_o) |-> !conversion_done_irq_o
            ##1 (!done_flag_o || !conversion_done_irq_o)
            ##1 (!done_flag_o || conversion_done_irq_o);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not two cycles after flag");

    property p_irq_cause;
        @(posedge sys_clk_i) disable iff (rst_i)
        conversion_done_irq_o |-> $past(done_flag_o, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without flag");

    property p_pwr;
        @(posedge sys_clk_i) disable iff (rst_i)
        !pwr_ok |-> !$rose(done_flag_o);
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("flag set before power-up settling");

    // a start while busy must not take a new window length
    property p_busy_ignore;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state != actc_pkg::ACTC_IDLE && start_i) |=> $stable(sh_len_reg);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("start accepted while busy");

    property p_clamp;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == actc_pkg::ACTC_LOAD && load_go && analog_over_i && !analog_under_i)
        |=> result_o == actc_pkg::CODE_MAX;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("over-range code not clamped");
endmodule
`default_nettype wire

// ---- rtl/actc_pkg.sv ----
`default_nettype none
package actc_pkg;
    // system clock
    localparam int unsigned CLK_PERIOD_PS      = 40000;
    localparam int unsigned CLK_FREQ_KHZ       = 25000;
    // result code range
    localparam logic [9:0]  CODE_MIN           = 10'h000;
    localparam logic [9:0]  CODE_MAX           = 10'h3FF;
    localparam int unsigned CODE_W             = 10;
    // start to sample/hold, system cycles
    localparam int unsigned SOC_DELAY_CYC      = 3;
    // result load after end of conversion, system cycles
    localparam int unsigned LOAD_DELAY_CYC     = 2;
    // flag to interrupt, system cycles
    localparam int unsigned IRQ_DELAY_CYC      = 2;
    // sample/hold window bounds, converter clocks
    localparam int unsigned SH_MIN_TICKS       = 2;
    localparam int unsigned SH_MAX_TICKS       = 32;
    localparam int unsigned PRESC_W            = 5;
    // conversion phase, converter clocks
    localparam int unsigned CONV_TICKS         = 10;
    // shortest converter clock period, in ps
    localparam int unsigned ADCLK_MIN_PS       = 33300;
    localparam int unsigned ADCLK_DIV          = (ADCLK_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // whole conversion floor, in ns
    localparam int unsigned TOTAL_MIN_NS       = 500;
    localparam int unsigned TOTAL_MIN_CYC      = (TOTAL_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                                 / CLK_PERIOD_PS;
    // power-up settling, in us
    localparam int unsigned PWRUP_US           = 10;
    localparam int unsigned PWRUP_CYC          = (PWRUP_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int unsigned CNT_W              = 9;
    localparam int unsigned TICK_W             = 6;

    typedef enum logic [2:0] {
        ACTC_IDLE,
        ACTC_START,
        ACTC_SAMPLE,
        ACTC_CONVERT,
        ACTC_LOAD
    } actc_state_type;
endpackage
`default_nettype wire

// ---- rtl/actc_tick_div.sv ----
`timescale 1ns/100ps
`default_nettype none
module actc_tick_div #(
    parameter int unsigned DIV = 1
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    output logic      tick_o
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] count;

    // restarted by run_i low so the first tick is a full period away
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (!run_i || count == LAST) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    // not registered: a registered tick would stretch every phase by one cycle
    assign tick_o = run_i && (count == LAST);
endmodule
`default_nettype wire

// ---- sim/actc_analog_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module actc_analog_model (
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        sample_i,
    input  wire logic [actc_pkg::CODE_W-1:0] level_i,
    input  wire logic                        over_req_i,
    input  wire logic                        under_req_i,
    output logic      [actc_pkg::CODE_W-1:0] code_o,
    output logic                             over_o,
    output logic                             under_o
);
    // follows the input while sampling, frozen through conversion
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            code_o  <= 10'h000;
            over_o  <= 1'b0;
            under_o <= 1'b0;
        end else if (sample_i) begin
            code_o  <= level_i;
            over_o  <= over_req_i;
            under_o <= under_req_i;
        end
    end
endmodule
`default_nettype wire

// ---- sim/adc_conversion_timing_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_timing_control_tb;
    localparam int PWRUP = 40;
    logic       clk = 0, rst_i = 1, start_i = 0, clr = 0, ov_r = 0, un_r = 0;
    logic [4:0] presc = 5'h00;
    logic [9:0] level = 10'h000;
    wire logic [9:0] code, result;
    wire logic  ov, un, sample, convert, busy, flag, irq;
    int         n_mismatch = 0, n_tests = 0;
    int         t_s, n_s, n_c, tf, ti, t_ce, t_r;

    always #20 clk = ~clk;

    actc_analog_model model (.sys_clk_i(clk), .rst_i(rst_i), .sample_i(sample),
        .level_i(level), .over_req_i(ov_r), .under_req_i(un_r), .code_o(code),
        .over_o(ov), .under_o(un));

    actc_core #(.PWRUP_CYCLES(PWRUP)) uut (.sys_clk_i(clk), .rst_i(rst_i),
        .start_i(start_i), .acquisition_window_prescaler_i(presc),
        .analog_code_i(code), .analog_over_i(ov), .analog_under_i(un),
        .flag_clear_i(clr), .sample_o(sample), .convert_o(convert), .busy_o(busy),
        .result_o(result), .done_flag_o(flag), .conversion_done_irq_o(irq));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // one conversion; poke raises start again while converting
    task automatic run(input logic [4:0] p, input logic [9:0] lv, input logic o, u, poke);
        logic [9:0] r0;
        logic       seen;
        @(negedge clk) clr = 1;
        presc = p; level = lv; ov_r = o; un_r = u;
        @(negedge clk) clr = 0;
        start_i = 1;
        @(negedge clk) start_i = 0;
        r0 = result; seen = 0;
        t_s = -1; n_s = 0; n_c = 0; tf = -1; ti = -1; t_ce = -1; t_r = -1;
        for (int i = 0; i < 200; i++) begin
            if (sample && t_s < 0) t_s = i;
            n_s += sample;
            n_c += convert;
            if (convert) t_ce = i;
            if (result !== r0 && t_r < 0) t_r = i;
            if (flag && tf < 0) tf = i;
            if (irq && ti < 0) ti = i;
            start_i = poke && convert;
            seen |= busy;
            if (seen && !busy && (tf < 0 || i >= tf + 3)) break;
            @(negedge clk);
        end
        start_i = 0;
    endtask

    task automatic conv(input logic [4:0] p, input logic [9:0] lv, input logic o, u,
                        input logic [9:0] exp_r, input logic exp_f);
        run(p, lv, o, u, 1'b0);
        check("sample_cycles", (p < 1) ? 2 : p + 1, n_s);
        check("conv_cycles", 10, n_c);
        check("start_delay", 1, t_s >= 3);
        check("load_delay", 1, t_r - t_ce >= 2);
        check("result", exp_r, result);
        check("flag", exp_f, flag);
        check("busy_after", 0, busy);
        if (exp_f) begin
            check("total_cycles", 1, tf >= actc_pkg::TOTAL_MIN_CYC);
            check("irq_delay", 2, ti - tf);
        end
    endtask

    task automatic ignore_busy();
        int n;
        run(5'h02, 10'h111, 1'b0, 1'b0, 1'b1);
        n = 0;
        repeat (20) @(negedge clk) n += sample;
        check("extra_windows", 0, n);
        check("result_poke", 10'h111, result);
        @(negedge clk) clr = 1;
        @(negedge clk) clr = 0;
        check("flag_clear", 0, flag);
        @(negedge clk);
        check("irq_clear", 0, irq);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(40 * 4000);
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (3) @(negedge clk);
        rst_i = 0;
        check("rst_result", 10'h000, result);
        check("rst_flag", 0, flag | irq | busy);
        // first conversion inside settling: loads but never flags
        conv(5'h00, 10'h155, 1'b0, 1'b0, 10'h155, 1'b0);
        repeat (PWRUP) @(negedge clk);
        conv(5'h00, 10'h2AA, 1'b0, 1'b0, 10'h2AA, 1'b1);
        conv(5'h01, 10'h123, 1'b0, 1'b0, 10'h123, 1'b1);
        conv(5'h05, 10'h0F0, 1'b0, 1'b0, 10'h0F0, 1'b1);
        conv(5'h1F, 10'h3C3, 1'b0, 1'b0, 10'h3C3, 1'b1);
        conv(5'h07, 10'h010, 1'b1, 1'b0, 10'h3FF, 1'b1);
        conv(5'h07, 10'h100, 1'b0, 1'b1, 10'h000, 1'b1);
        conv(5'h03, 10'h001, 1'b0, 1'b0, 10'h001, 1'b1);
        conv(5'h03, 10'h200, 1'b1, 1'b1, 10'h000, 1'b1);
        ignore_busy();
        final_report();
    end
endmodule
`default_nettype wire
